// ---- analog_delay_filter.sv ----
// persistence filter: the output follows a level only after it has held steady
`timescale 1ns/1ps
module analog_delay_filter
  import ext_irq_pkg::*;
#(
  parameter int DELAY_CYC = ANALOG_DELAY_CYC
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // level
  input  wire logic din,
  output logic      dout
);

  logic [7:0] hold_cnt;
  wire        differs = din != dout;
  wire        settled = hold_cnt >= 8'(DELAY_CYC - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt <= 8'h00;
      dout     <= 1'b0;
    end else if (!differs) begin
      hold_cnt <= 8'h00;
    end else if (settled) begin
      hold_cnt <= 8'h00;
      dout     <= din;
    end else begin
      hold_cnt <= hold_cnt + 8'h01;
    end
  end

endmodule : analog_delay_filter

// ---- digital_sample_filter.sv ----
// sampling noise filter: a level change needs N equal consecutive samples
`timescale 1ns/1ps
module digital_sample_filter
  import ext_irq_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic sample_en,
  input  wire logic two_samples,
  input  wire logic restart,
  // level
  input  wire logic din,
  output logic      dout
);

  logic [2:0] samples;
  logic [1:0] fill;
  wire  [1:0] need      = two_samples ? 2'(SAMPLES_TWO) : 2'(SAMPLES_THREE);
  wire        all_three = (samples == 3'b111) || (samples == 3'b000);
  wire        all_two   = samples[1] == samples[0];
  wire        agree     = (fill >= need) && (two_samples ? all_two : all_three);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samples <= 3'b000;
      fill    <= 2'h0;
      dout    <= 1'b0;
    end else if (restart) begin
      fill    <= 2'h0;
    end else if (sample_en) begin
      samples <= {samples[1:0], din};
      if (fill != 2'h3) begin
        fill <= fill + 2'h1;
      end
    end else if (agree) begin
      dout    <= samples[0];
    end
  end

endmodule : digital_sample_filter

// ---- ext_irq_edge_detect_filter.sv ----
// external request pins: filtering, edge selection, request pulses and apb registers
`timescale 1ns/1ps
module ext_irq_edge_detect_filter
  import ext_irq_pkg::*;
#(
  parameter int DELAY_CYC = ANALOG_DELAY_CYC
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // pins and clocks
  input  wire logic [7:0]        ext_req_pins,
  input  wire logic              nmi_pin,
  input  wire logic              subclk,
  input  wire logic              standby,
  // requests
  output logic                   nmi_req,
  output logic      [7:0]        int_req,
  output logic                   standby_wake,
  output logic                   irq
);

  // ---------------- registers ----------------
  logic [7:0]          fall0;
  logic [7:0]          rise0;
  logic [7:0]          rise3;
  logic [7:0]          fall3;
  logic [7:0]          fall9;
  logic [7:0]          rise9;
  logic [7:0]          noise_filter_control;
  logic [8:0]          status;
  logic [8:0]          mask;
  logic [8:0]          read_snap;

  // ---------------- apb decode ----------------
  wire        setup     = psel && !penable && !pready;
  wire        done      = psel && penable && pready;
  wire        wr_done   = done && pwrite && !pslverr;
  wire        rd_done   = done && !pwrite;
  wire [7:0]  wbyte     = pwdata[7:0];
  wire        hit_f0    = paddr == FALL0_ADDR;
  wire        hit_r0    = paddr == RISE0_ADDR;
  wire        hit_r3    = paddr == RISE3_ADDR;
  wire        hit_f3    = paddr == FALL3_ADDR;
  wire        hit_f9    = paddr == FALL9_ADDR;
  wire        hit_r9    = paddr == RISE9_ADDR;
  wire        hit_nfc   = paddr == NFC_ADDR;
  wire        hit_stat  = paddr == STATUS_ADDR;
  wire        hit_mask  = paddr == MASK_ADDR;
  wire        mapped    = hit_f0 | hit_r0 | hit_r3 | hit_f3 | hit_f9 |
                          hit_r9 | hit_nfc | hit_stat | hit_mask;
  wire [31:0] rd_mux    = hit_f0   ? {24'h000000, fall0} :
                          hit_r0   ? {24'h000000, rise0} :
                          hit_r3   ? {24'h000000, rise3} :
                          hit_f3   ? {24'h000000, fall3} :
                          hit_f9   ? {24'h000000, fall9} :
                          hit_r9   ? {24'h000000, rise9} :
                          hit_nfc  ? {24'h000000, noise_filter_control}   :
                          hit_stat ? {23'h000000, status} :
                          hit_mask ? {23'h000000, mask}  : 32'h00000000;

  // no wait state: pready rises the cycle after setup, so every answer is registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h00000000;
      read_snap <= 9'h000;
    end else begin
      pready    <= setup;
      pslverr   <= setup && !mapped;
      if (setup) begin
        prdata    <= pwrite ? 32'h00000000 : rd_mux;
        read_snap <= (!pwrite && hit_stat) ? status : 9'h000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fall0 <= SEL_RESET;
      rise0 <= SEL_RESET;
      rise3 <= SEL_RESET;
      fall3 <= SEL_RESET;
      fall9 <= SEL_RESET;
      rise9 <= SEL_RESET;
      noise_filter_control   <= NFC_RESET;
      mask  <= MASK_RESET;
    end else if (wr_done) begin
      if (hit_f0)   fall0 <= wbyte & GRP0_WMASK;
      if (hit_r0)   rise0 <= wbyte & GRP0_WMASK;
      if (hit_r3)   rise3 <= wbyte & GRP3_WMASK;
      if (hit_f3)   fall3 <= wbyte & GRP3_WMASK;
      if (hit_f9)   fall9 <= wbyte & GRP9_WMASK;
      if (hit_r9)   rise9 <= wbyte & GRP9_WMASK;
      if (hit_nfc)  noise_filter_control   <= wbyte & NFC_WMASK;
      if (hit_mask) mask  <= pwdata[8:0];
    end
  end

  // ---------------- edge select mapping ----------------
  edge_sel_s sel;
  assign sel.fall = {fall0[GRP0_NMI_BIT],
                     fall3[GRP3_PIN7_BIT],
                     fall9[GRP9_PIN4_BIT +: 3],
                     fall0[GRP0_PIN0_BIT +: 4]};
  assign sel.rise = {rise0[GRP0_NMI_BIT],
                     rise3[GRP3_PIN7_BIT],
                     rise9[GRP9_PIN4_BIT +: 3],
                     rise0[GRP0_PIN0_BIT +: 4]};

  filt_cfg_s cfg;
  assign cfg.digital     = noise_filter_control[NFC_EN_BIT];
  assign cfg.two_samples = noise_filter_control[NFC_CNT_BIT];
  assign cfg.clk_sel     = noise_filter_control[2:0];

  // ---------------- sample clock ----------------
  // the fxx taps stop while in standby, modelling the halted system clock
  logic [DIV_W-1:0] div_cnt;
  logic             subclk_q;
  logic [2:0]       clk_sel_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt   <= '0;
      subclk_q  <= 1'b0;
      clk_sel_q <= SCLK_DIV64;
    end else begin
      if (!standby) begin
        div_cnt <= div_cnt + DIV_W'(1);
      end
      subclk_q  <= subclk;
      clk_sel_q <= cfg.clk_sel;
    end
  end

  logic [4:0] div_tick;
  genvar k;
  generate
    for (k = 0; k < 5; k++) begin : g_tap
      assign div_tick[k] = !standby && (&div_cnt[DIV64_LOG2 + k - 1:0]);
    end
  endgenerate

  wire sub_tick   = subclk && !subclk_q;
  wire fxx_code   = cfg.clk_sel <= SCLK_DIV1024;
  wire sub_code   = cfg.clk_sel == SCLK_SUB;
  // prohibited codes give no sample enable, so the digital filter simply holds
  wire sample_en  = fxx_code ? div_tick[cfg.clk_sel] : (sub_code && sub_tick);
  wire clk_change = clk_sel_q != cfg.clk_sel;

  // ---------------- filtering ----------------
  wire [NUM_PINS-1:0] raw_pins = {nmi_pin, ext_req_pins};
  wire [NUM_PINS-1:0] analog_lvl;
  wire                digital_lvl;

  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p++) begin : g_afilt
      analog_delay_filter #(
        .DELAY_CYC (DELAY_CYC)
      ) u_afilt (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (raw_pins[p]),
        .dout    (analog_lvl[p])
      );
    end
  endgenerate

  digital_sample_filter u_dfilt (
    .pclk        (pclk),
    .presetn     (presetn),
    .sample_en   (sample_en),
    .two_samples (cfg.two_samples),
    .restart     (clk_change),
    .din         (raw_pins[FILT_PIN]),
    .dout        (digital_lvl)
  );

  // the nmi never goes through the sampling filter so it still works when fxx is halted
  wire [NUM_PINS-1:0] filt_lvl;
  generate
    for (p = 0; p < NUM_PINS; p++) begin : g_sel
      if (p == FILT_PIN) begin : g_dig
        assign filt_lvl[p] = cfg.digital ? digital_lvl : analog_lvl[p];
      end else begin : g_ana
        assign filt_lvl[p] = analog_lvl[p];
      end
    end
  endgenerate

  // ---------------- edge detection ----------------
  logic [NUM_PINS-1:0] prev_lvl;
  wire  [NUM_PINS-1:0] rose   = filt_lvl & ~prev_lvl;
  wire  [NUM_PINS-1:0] fell   = ~filt_lvl & prev_lvl;
  wire  [NUM_PINS-1:0] detect = (rose & sel.rise) | (fell & sel.fall);

  // pin 3 on a halted sample clock cannot reach the wake logic
  wire pin3_stalled  = cfg.digital && !sub_code;
  wire [NUM_PINS-1:0] wake_src = {detect[NUM_PINS-1:FILT_PIN+1],
                                  detect[FILT_PIN] && !(standby && pin3_stalled),
                                  detect[FILT_PIN-1:0]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_lvl     <= '0;
      nmi_req      <= 1'b0;
      int_req      <= 8'h00;
      standby_wake <= 1'b0;
    end else begin
      prev_lvl     <= filt_lvl;
      nmi_req      <= detect[NMI_IDX];
      int_req      <= detect[7:0];
      standby_wake <= standby && (|wake_src);
    end
  end

  // ---------------- request flags and interrupt ----------------
  // a new request in the clearing cycle survives, and only bits returned by the read clear
  wire [8:0] set_bits = {nmi_req, int_req};
  wire [8:0] clr_bits = rd_done ? read_snap : 9'h000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= STATUS_RESET;
      irq    <= 1'b0;
    end else begin
      status <= (status & ~clr_bits) | set_bits;
      irq    <= |(((status & ~clr_bits) | set_bits) & mask);
    end
  end

endmodule : ext_irq_edge_detect_filter

// ---- ext_irq_pkg.sv ----
// constants, field layouts and carriers for the external request edge detector
// What this block does
// - each pin detects rising, falling, both or none
// - group0 bit2 nmi, bits3-6 pins0-3
// - group3 select pair controls pin 7
// - group9 select pair controls pins 4-6
// - reset clears all selects and filter control
// - nmi raises nothing until an edge enabled
// - every pin but a digitally filtered pin 3 passes a persistence delay filter
// - pin 3 picks analog or digital filter
// - three-bit code picks sample clock source
// - digital filter needs three or two samples
// - filter re-initialises after sample clock change
// - stopped sample clock blocks pin3 standby release
// - pulses up to two samples (one sample in two-sample mode) are rejected
// - nmi releases stop through undelayed-clock path
package ext_irq_pkg;

  localparam int          ADDR_W             = 28;
  localparam int          NUM_PINS           = 9;
  localparam int          NMI_IDX            = 8;
  localparam int          FILT_PIN           = 3;

  // register byte addresses
  localparam logic [27:0] FALL0_ADDR         = 28'hffff300;
  localparam logic [27:0] RISE0_ADDR         = 28'hffff304;
  localparam logic [27:0] RISE3_ADDR         = 28'hffff308;
  localparam logic [27:0] FALL3_ADDR         = 28'hffff30c;
  localparam logic [27:0] FALL9_ADDR         = 28'hffff310;
  localparam logic [27:0] RISE9_ADDR         = 28'hffff314;
  localparam logic [27:0] NFC_ADDR           = 28'hffff318;
  localparam logic [27:0] STATUS_ADDR        = 28'hffff31c;
  localparam logic [27:0] MASK_ADDR          = 28'hffff320;

  // field positions
  localparam int          GRP0_NMI_BIT       = 2;
  localparam int          GRP0_PIN0_BIT      = 3;
  localparam int          GRP3_PIN7_BIT      = 1;
  localparam int          GRP9_PIN4_BIT      = 5;
  localparam int          NFC_EN_BIT         = 7;
  localparam int          NFC_CNT_BIT        = 6;
  localparam logic [7:0]  GRP0_WMASK         = 8'h7c;
  localparam logic [7:0]  GRP3_WMASK         = 8'h02;
  localparam logic [7:0]  GRP9_WMASK         = 8'he0;
  localparam logic [7:0]  NFC_WMASK          = 8'hc7;

  // reset values
  localparam logic [7:0]  SEL_RESET          = 8'h00;
  localparam logic [7:0]  NFC_RESET          = 8'h00;
  localparam logic [8:0]  STATUS_RESET       = 9'h000;
  localparam logic [8:0]  MASK_RESET         = 9'h000;

  // sample clock codes
  localparam logic [2:0]  SCLK_DIV64         = 3'h0;
  localparam logic [2:0]  SCLK_DIV1024       = 3'h4;
  localparam logic [2:0]  SCLK_SUB           = 3'h5;
  localparam int          DIV_W              = 10;
  localparam int          DIV64_LOG2         = 6;

  // timing
  localparam int          CLK_PERIOD_NS      = 25;
  localparam int          ANALOG_DELAY_NS    = 60;
  localparam int          ANALOG_DELAY_CYC   = (ANALOG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SAMPLES_THREE      = 3;
  localparam int          SAMPLES_TWO        = 2;

  typedef struct packed {
    logic [NUM_PINS-1:0] fall;
    logic [NUM_PINS-1:0] rise;
  } edge_sel_s;

  typedef struct packed {
    logic       digital;
    logic       two_samples;
    logic [2:0] clk_sel;
  } filt_cfg_s;

endpackage : ext_irq_pkg

// ---- ext_irq_properties.sv ----
// port assertions for the external request edge detector
`timescale 1ns/1ps
module ext_irq_checker
  import ext_irq_pkg::*;
#(
  parameter int DELAY_CYC = ANALOG_DELAY_CYC
) (
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // pins and requests
  input wire logic [7:0]        ext_req_pins,
  input wire logic              nmi_pin,
  input wire logic              subclk,
  input wire logic              standby,
  input wire logic              nmi_req,
  input wire logic [7:0]        int_req,
  input wire logic              standby_wake,
  input wire logic              irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic mapped = (paddr >= FALL0_ADDR) && (paddr <= MASK_ADDR) && (paddr[1:0] == 2'b00);
  wire logic mask_wr = psel && penable && pready && pwrite && (paddr == MASK_ADDR);
  wire logic any_req = nmi_req || (int_req != 8'h00);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    pready ##1 !pready;
  endsequence
  a_apb_answer: assert property (setup_s |=> answer_s)
    else $error("apb answer not one cycle");
  a_unmapped_err: assert property (pready |-> pslverr == !mapped)
    else $error("error response wrong for address");
  a_write_zero: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("write returned data");
  a_reset_quiet: assert property ($rose(presetn) |-> !irq && !any_req && !pready)
    else $error("outputs active after reset");
  a_req_single: assert property (int_req != 8'h00 |=> (int_req & $past(int_req)) == 8'h00)
    else $error("request pulse longer than one cycle");
  a_nmi_single: assert property (nmi_req |=> !nmi_req)
    else $error("nmi pulse longer than one cycle");
  a_irq_cause: assert property ($rose(irq) |-> $past(any_req) || $past(mask_wr, 2))
    else $error("irq rose without cause");
  a_wake_cause: assert property (standby_wake |-> $past(standby) && any_req)
    else $error("wake without standby edge");
  a_nmi_settled: assert property (nmi_req |-> $stable(nmi_pin) && $past(nmi_pin) == $past(nmi_pin, 2))
    else $error("nmi request on unsettled pin");
endmodule : ext_irq_checker

bind ext_irq_edge_detect_filter ext_irq_checker #(.DELAY_CYC(DELAY_CYC)) u_ext_irq_checker (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .ext_req_pins, .nmi_pin, .subclk, .standby, .nmi_req, .int_req, .standby_wake, .irq
);

// ---- ext_pin_source.sv ----
// external request sources: pin levels and a free running subclock
`timescale 1ns/1ps
module ext_pin_source
  import ext_irq_pkg::*;
(
  // clock
  input  wire logic pclk,
  // pins
  output logic [7:0] ext_req_pins,
  output logic       nmi_pin,
  output logic       subclk
);
  logic [2:0] div;
  initial begin
    ext_req_pins = 8'h00;
    nmi_pin = 1'b0;
    subclk = 1'b0;
    div = 3'h0;
  end
  // the crystal never stops, so the subclock runs at pclk/8 regardless of requests
  always @(posedge pclk) begin
    div <= div + 3'h1;
    subclk <= div[2];
  end
  task automatic drive(input int idx, input logic v, input int hold);
    if (idx == NMI_IDX) nmi_pin <= v;
    else ext_req_pins[idx] <= v;
    repeat (hold) @(posedge pclk);
  endtask : drive
endmodule : ext_pin_source

// ---- tb_ext_irq_edge_detect_filter.sv ----
// self-checking bench for the external request edge detector
`timescale 1ns/1ps
module tb_ext_irq_edge_detect_filter
  import ext_irq_pkg::*;
;
  localparam int DLY = 3;
  localparam int          PN [4] = '{8, 0, 7, 4};
  localparam int          BT [4] = '{2, 3, 1, 5};
  localparam logic [27:0] FA [4] = '{FALL0_ADDR, FALL0_ADDR, FALL3_ADDR, FALL9_ADDR};
  localparam logic [27:0] RA [4] = '{RISE0_ADDR, RISE0_ADDR, RISE3_ADDR, RISE9_ADDR};
  logic              pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic              pwrite = 1'b0, standby = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata, q;
  logic              pready, pslverr, nmi_req, standby_wake, irq, nmi_pin, subclk, err;
  logic [7:0]        int_req, ext_req_pins;
  int                fails = 0, n_checks = 0, n_req = 0, n_wake = 0;

  ext_irq_edge_detect_filter #(.DELAY_CYC(DLY)) u_ext_irq_edge_detect_filter (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ext_req_pins, .nmi_pin, .subclk, .standby, .nmi_req, .int_req, .standby_wake, .irq);
  ext_pin_source u_ext_pin_source (.pclk, .ext_req_pins, .nmi_pin, .subclk);

  initial forever #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    n_req <= n_req + $countones({nmi_req, int_req});
    n_wake <= n_wake + int'(standby_wake);
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [27:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    // a slave that never answers counts against the run
    if (pready !== 1'b1) begin
      fails++;
      $display("[ERR] apb answer expected 1 seen %b", pready);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic sel(input logic [27:0] fa, input logic [27:0] ra, input int b, input logic [1:0] m);
    apb(1'b1, fa, 32'(m[1]) << b);
    apb(1'b1, ra, 32'(m[0]) << b);
  endtask : sel
  task automatic pulse(input int pin, input int w, input int exp, input string what);
    int n0;
    n0 = n_req;
    u_ext_pin_source.drive(pin, 1'b1, w);
    u_ext_pin_source.drive(pin, 1'b0, 60);
    chk(what, n_req - n0, exp);
  endtask : pulse

  task automatic t_reset;
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, FALL0_ADDR + 28'(4 * i), 32'h0);
      chk("reset value", q, 32'h0);
    end
    pulse(NMI_IDX, 10, 0, "nmi unselected");
    apb(1'b1, FALL0_ADDR, 32'hff);
    apb(1'b0, FALL0_ADDR, 32'h0);
    chk("group0 bits", q, 32'(GRP0_WMASK));
    apb(1'b0, 28'h0000200, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
  endtask : t_reset
  task automatic t_edges;
    for (int p = 0; p < 4; p++) begin
      for (int m = 0; m < 4; m++) begin
        sel(FA[p], RA[p], BT[p], 2'(m));
        pulse(PN[p], 10, $countones(m), "edge count");
      end
      sel(FA[p], RA[p], BT[p], 2'b00);
    end
  endtask : t_edges
  task automatic t_filter;
    sel(FALL0_ADDR, RISE0_ADDR, 4, 2'b01);
    pulse(1, DLY - 1, 0, "short pulse");
    pulse(1, DLY, 1, "held pulse");
  endtask : t_filter
  task automatic t_irq;
    sel(FALL0_ADDR, RISE0_ADDR, 3, 2'b01);
    apb(1'b0, STATUS_ADDR, 32'h0);
    pulse(0, 10, 1, "pin0 rise");
    chk("irq masked", 32'(irq), 32'h0);
    apb(1'b1, MASK_ADDR, 32'h1);
    repeat (3) @(posedge pclk);
    chk("irq unmasked", 32'(irq), 32'h1);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("status", q, 32'h1);
    repeat (3) @(posedge pclk);
    chk("irq cleared", 32'(irq), 32'h0);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("status cleared", q, 32'h0);
  endtask : t_irq
  task automatic t_digital;
    int n0;
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, NFC_ADDR, 32'h80 | c);
      apb(1'b0, NFC_ADDR, 32'h0);
      chk("filter control", q, 32'h80 | c);
    end
    sel(FALL0_ADDR, RISE0_ADDR, 6, 2'b01);
    apb(1'b1, NFC_ADDR, 32'h80 | SCLK_SUB);
    // settle the sampler before trusting the flag, else a stale edge may post
    repeat (3 * 8) @(posedge pclk);
    apb(1'b0, STATUS_ADDR, 32'h0);
    pulse(3, 15, 0, "narrow pulse");
    pulse(3, 60, 1, "three samples");
    apb(1'b1, NFC_ADDR, 32'hc0 | SCLK_SUB);
    repeat (2 * 8) @(posedge pclk);
    pulse(3, 17, 1, "two samples");
    standby <= 1'b1;
    n0 = n_wake;
    pulse(3, 60, 1, "sub sampled req");
    chk("sub wake", n_wake - n0, 1);
    apb(1'b1, NFC_ADDR, 32'h80 | SCLK_DIV64);
    pulse(3, 200, 0, "halted sampling");
    sel(FALL0_ADDR, RISE0_ADDR, 2, 2'b01);
    pulse(NMI_IDX, 10, 1, "nmi in standby");
    chk("wakes", n_wake - n0, 2);
    standby <= 1'b0;
  endtask : t_digital

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_edges;
    t_filter;
    t_irq;
    t_digital;
    final_report;
  end
  initial begin
    repeat (40000) @(posedge pclk);
    fails++;
    final_report;
  end
endmodule : tb_ext_irq_edge_detect_filter
